/* verilog/arc_top.sv */
// analog speed reference conditioner: two inputs, loss handling, wishbone registers
`timescale 1ns/1ps
module arc_top (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               ce_i,
   // wishbone slave
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   // converter samples, mV or uA
   input  wire logic               ain1_vld_i,
   input  wire logic signed [15:0] ain1_i,
   input  wire logic               ain2_vld_i,
   input  wire logic signed [15:0] ain2_i,
   // fault reset from the drive
   input  wire logic               fault_rst_i,
   // demand and status
   output logic      [15:0]        speed_o,
   output logic                    reverse_o,
   output logic                    ramp_stop_o,
   output logic                    fault_o,
   output logic      [7:0]         fault_code_o,
   output logic                    irq_o
);
   import arc_pkg::*;

   // ****************************************
   // types and declarations
   // ****************************************
   typedef enum logic [2:0] {
      ST_RUN   = 3'h1,
      ST_RAMP  = 3'h2,
      ST_FAULT = 3'h4
   } arc_state_t;

   arc_state_t         st_d;
   arc_state_t         st_q;

   logic [8:0]         ctrl_d;
   logic [8:0]         ctrl_q;
   logic signed [15:0] ofs1_d;
   logic signed [15:0] ofs1_q;
   logic        [15:0] scl1_d;
   logic        [15:0] scl1_q;
   logic signed [15:0] ofs2_d;
   logic signed [15:0] ofs2_q;
   logic        [15:0] scl2_d;
   logic        [15:0] scl2_q;
   logic        [15:0] maxsp_d;
   logic        [15:0] maxsp_q;
   logic        [31:0] rdat_d;
   logic        [31:0] rdat_q;
   logic               ack_d;
   logic               ack_q;
   logic        [15:0] speed_d;
   logic        [15:0] speed_q;
   logic               rev_d;
   logic               rev_q;

   logic               acc;
   logic               wr;
   logic               rd;
   logic               sw_frst;
   logic               frst;
   arc_fmt_t           fmt1;
   arc_fmt_t           fmt2;
   arc_cfg_t           cfg1;
   arc_cfg_t           cfg2;
   arc_res_t           res1;
   arc_res_t           res2;
   arc_res_t           ref_r;
   logic               trip_req;
   logic               ramp_req;
   logic               any_lost;
   logic               any_lost_q;
   logic [ARC_IRQ_N-1:0] ev;
   logic [ARC_IRQ_N-1:0] istat;
   logic [ARC_IRQ_N-1:0] imask;
   logic [15:0]        mag;
   logic [34:0]        sp_w;

   // merge written bytes into a register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ****************************************
   // format selection
   // ****************************************
   always_comb begin
      fmt1 = ARC_FMT_U10;
      if (ctrl_q[ARC_CTRL_FMT1 +: 3] != 3'h7) begin
         fmt1 = arc_fmt_t'(ctrl_q[ARC_CTRL_FMT1 +: 3]);
      end
      // second input only offers three formats
      unique case (ctrl_q[ARC_CTRL_FMT2 +: 2])
         2'h1:    fmt2 = ARC_FMT_A20;
         2'h2:    fmt2 = ARC_FMT_T420;
         default: fmt2 = ARC_FMT_U10;
      endcase
      cfg1 = '{fmt: fmt1, offset: ofs1_q, scale: scl1_q};
      cfg2 = '{fmt: fmt2, offset: ofs2_q, scale: scl2_q};
   end

   // ****************************************
   // input channels
   // ****************************************
   arc_chan u_ch1 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .smp_vld_i (ain1_vld_i),
      .smp_i     (ain1_i),
      .cfg_i     (cfg1),
      .res_o     (res1)
   );

   arc_chan u_ch2 (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .smp_vld_i (ain2_vld_i),
      .smp_i     (ain2_i),
      .cfg_i     (cfg2),
      .res_o     (res2)
   );

   // ****************************************
   // loss handling state
   // ****************************************
   always_comb begin
      trip_req = (res1.lost && res1.trip) || (res2.lost && res2.trip);
      ramp_req = (res1.lost && !res1.trip) || (res2.lost && !res2.trip);
      any_lost = res1.lost || res2.lost;
      frst     = fault_rst_i || sw_frst;
      st_d     = st_q;
      unique case (st_q)
         ST_RUN: begin
            if (trip_req) begin
               st_d = ST_FAULT;
            end else if (ramp_req) begin
               st_d = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (trip_req) begin
               st_d = ST_FAULT;
            end else if (!ramp_req) begin
               st_d = ST_RUN;
            end
         end
         ST_FAULT: begin
            // recovery of the signal alone does not clear the fault
            if (frst) begin
               st_d = ST_RUN;
            end
         end
         default: st_d = ST_FAULT;
      endcase
      ev                = '0;
      ev[ARC_IRQ_TRIP]  = (st_q != ST_FAULT) && (st_d == ST_FAULT);
      ev[ARC_IRQ_RAMP]  = (st_q == ST_RUN) && (st_d == ST_RAMP);
      ev[ARC_IRQ_RECOV] = any_lost_q && !any_lost;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q       <= ST_RUN;
         any_lost_q <= 1'b0;
      end else if (ce_i) begin
         st_q       <= st_d;
         any_lost_q <= any_lost;
      end
   end

   // ****************************************
   // speed demand
   // ****************************************
   always_comb begin
      ref_r = ctrl_q[ARC_CTRL_SEL] ? res2 : res1;
      mag   = ref_r.value[15] ? 16'(-ref_r.value) : ref_r.value;
      sp_w  = 35'(mag * maxsp_q) / 35'(ARC_FULL);
      speed_d = '0;
      rev_d   = rev_q;
      // ramp generator outside brings the motor down from here
      if (st_q == ST_RUN) begin
         speed_d = sp_w[15:0];
         rev_d   = ref_r.value[15];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         speed_q <= '0;
         rev_q   <= 1'b0;
      end else if (ce_i) begin
         speed_q <= speed_d;
         rev_q   <= rev_d;
      end
   end

   assign speed_o      = speed_q;
   assign reverse_o    = rev_q;
   assign ramp_stop_o  = (st_q == ST_RAMP);
   assign fault_o      = (st_q == ST_FAULT);
   assign fault_code_o = (st_q == ST_FAULT) ? ARC_INPUT_LOSS_FAULT_CODE : 8'h00;

   // ****************************************
   // wishbone register file
   // ****************************************
   assign acc     = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr      = acc && wb_we_i;
   assign rd      = acc && !wb_we_i;
   assign sw_frst = wr && (wb_adr_i == ARC_REG_CMD) && wb_sel_i[0] && wb_dat_i[0];

   always_comb begin
      ctrl_d  = ctrl_q;
      ofs1_d  = ofs1_q;
      scl1_d  = scl1_q;
      ofs2_d  = ofs2_q;
      scl2_d  = scl2_q;
      maxsp_d = maxsp_q;
      ack_d   = acc;
      rdat_d  = rdat_q;
      if (wr) begin
         unique case (wb_adr_i)
            ARC_REG_CTRL:  ctrl_d  = 9'(merge(32'(ctrl_q), wb_dat_i, wb_sel_i));
            ARC_REG_OFS1:  ofs1_d  = 16'(merge(32'(ofs1_q), wb_dat_i, wb_sel_i));
            ARC_REG_SCL1:  scl1_d  = 16'(merge(32'(scl1_q), wb_dat_i, wb_sel_i));
            ARC_REG_OFS2:  ofs2_d  = 16'(merge(32'(ofs2_q), wb_dat_i, wb_sel_i));
            ARC_REG_SCL2:  scl2_d  = 16'(merge(32'(scl2_q), wb_dat_i, wb_sel_i));
            ARC_REG_MAXSP: maxsp_d = 16'(merge(32'(maxsp_q), wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
      if (rd) begin
         unique case (wb_adr_i)
            ARC_REG_CTRL:  rdat_d = 32'(ctrl_q);
            ARC_REG_OFS1:  rdat_d = {{16{ofs1_q[15]}}, ofs1_q};
            ARC_REG_SCL1:  rdat_d = 32'(scl1_q);
            ARC_REG_OFS2:  rdat_d = {{16{ofs2_q[15]}}, ofs2_q};
            ARC_REG_SCL2:  rdat_d = 32'(scl2_q);
            ARC_REG_MAXSP: rdat_d = 32'(maxsp_q);
            ARC_REG_STAT:  rdat_d = {16'h0000, fault_code_o, 2'h0, rev_q,
                                     res2.lost, res1.lost, st_q};
            ARC_REG_ISTAT: rdat_d = 32'(istat);
            ARC_REG_IMASK: rdat_d = 32'(imask);
            ARC_REG_DEM:   rdat_d = {speed_q, ref_r.value};
            default:       rdat_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q  <= '0;
         ofs1_q  <= ARC_OFS_RST;
         scl1_q  <= ARC_SCL_RST;
         ofs2_q  <= ARC_OFS_RST;
         scl2_q  <= ARC_SCL_RST;
         maxsp_q <= ARC_MAXSP_RST;
         ack_q   <= 1'b0;
         rdat_q  <= '0;
      end else if (ce_i) begin
         ctrl_q  <= ctrl_d;
         ofs1_q  <= ofs1_d;
         scl1_q  <= scl1_d;
         ofs2_q  <= ofs2_d;
         scl2_q  <= scl2_d;
         maxsp_q <= maxsp_d;
         ack_q   <= ack_d;
         rdat_q  <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ****************************************
   // interrupts
   // ****************************************
   arc_irq #(
      .N (ARC_IRQ_N)
   ) u_irq (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .ev_i      (ev),
      .rd_clr_i  (rd && (wb_adr_i == ARC_REG_ISTAT)),
      .mask_we_i (wr && (wb_adr_i == ARC_REG_IMASK) && wb_sel_i[0]),
      .mask_i    (wb_dat_i[ARC_IRQ_N-1:0]),
      .stat_o    (istat),
      .mask_o    (imask),
      .irq_o     (irq_o)
   );

endmodule // arc_top

/* verilog/arc_pkg.sv */
// shared types, register map and constants of the analog reference conditioner
package arc_pkg;

   // ****************************************
   // formats
   // ****************************************
   typedef enum logic [2:0] {
      ARC_FMT_U10  = 3'h0,   // 0..10 V unipolar
      ARC_FMT_B10  = 3'h1,   // -10..10 V bipolar
      ARC_FMT_A20  = 3'h2,   // 0..20 mA
      ARC_FMT_T420 = 3'h3,   // 4..20 mA, trip on loss
      ARC_FMT_R420 = 3'h4,   // 4..20 mA, ramp to stop on loss
      ARC_FMT_T204 = 3'h5,   // 20..4 mA, trip on loss
      ARC_FMT_R204 = 3'h6    // 20..4 mA, ramp to stop on loss
   } arc_fmt_t;

   // conditioning settings of one input; percentages in 0.1 % steps
   typedef struct packed {
      arc_fmt_t           fmt;
      logic signed [15:0] offset;
      logic        [15:0] scale;
   } arc_cfg_t;

   // conditioned result of one input
   typedef struct packed {
      logic signed [15:0] value;   // -1000..1000 = -100.0..100.0 %
      logic               lost;    // loop current under loss level
      logic               trip;    // loss handling is trip, else ramp
   } arc_res_t;

   // ****************************************
   // signal levels (mV for voltage, uA for current)
   // ****************************************
   localparam logic signed [17:0] ARC_LOSS_UA  = 18'h0_0bb8;  // 3 mA
   localparam logic signed [17:0] ARC_LOOP_MIN = 18'h0_0fa0;  // 4 mA
   localparam logic signed [17:0] ARC_LOOP_MAX = 18'h0_4e20;  // 20 mA
   localparam logic signed [17:0] ARC_DIV_V    = 18'h0_000a;  // mV per 0.1 %
   localparam logic signed [17:0] ARC_DIV_A    = 18'h0_0014;  // uA per 0.1 %, 0-20 mA
   localparam logic signed [17:0] ARC_DIV_LOOP = 18'h0_0010;  // uA per 0.1 %, 16 mA span
   localparam logic signed [34:0] ARC_FULL_W   = 35'h0_0000_03e8;
   localparam logic signed [15:0] ARC_FULL     = 16'h03e8;    // 100.0 %

   // ****************************************
   // reset values and input loss fault code
   // ****************************************
   localparam logic signed [15:0] ARC_OFS_RST   = 16'h0000;
   localparam logic        [15:0] ARC_SCL_RST   = 16'h03e8;
   localparam logic        [15:0] ARC_MAXSP_RST = 16'h01f4;
   localparam logic        [7:0]  ARC_INPUT_LOSS_FAULT_CODE = 8'h07;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ARC_REG_CTRL  = 8'h00;
   localparam logic [7:0] ARC_REG_OFS1  = 8'h04;
   localparam logic [7:0] ARC_REG_SCL1  = 8'h08;
   localparam logic [7:0] ARC_REG_OFS2  = 8'h0c;
   localparam logic [7:0] ARC_REG_SCL2  = 8'h10;
   localparam logic [7:0] ARC_REG_MAXSP = 8'h14;
   localparam logic [7:0] ARC_REG_CMD   = 8'h18;
   localparam logic [7:0] ARC_REG_STAT  = 8'h1c;
   localparam logic [7:0] ARC_REG_ISTAT = 8'h20;
   localparam logic [7:0] ARC_REG_IMASK = 8'h24;
   localparam logic [7:0] ARC_REG_DEM   = 8'h28;

   // ctrl fields
   localparam int unsigned ARC_CTRL_FMT1 = 0;   // [2:0]
   localparam int unsigned ARC_CTRL_FMT2 = 4;   // [5:4]
   localparam int unsigned ARC_CTRL_SEL  = 8;   // reference source

   // interrupt events
   localparam int unsigned ARC_IRQ_N     = 3;
   localparam int unsigned ARC_IRQ_TRIP  = 0;
   localparam int unsigned ARC_IRQ_RAMP  = 1;
   localparam int unsigned ARC_IRQ_RECOV = 2;

   // saturate a wide signed value to +-100.0 %
   function automatic logic signed [15:0] arc_clamp(input logic signed [34:0] v);
      if (v > ARC_FULL_W) begin
         return ARC_FULL;
      end else if (v < -ARC_FULL_W) begin
         return -ARC_FULL;
      end
      return v[15:0];
   endfunction

endpackage

/* verilog/arc_chan.sv */
// one analog input: format decode, offset, scaling, loss detection
`timescale 1ns/1ps
module arc_chan (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               ce_i,
   // converter sample: mV or uA, signed
   input  wire logic               smp_vld_i,
   input  wire logic signed [15:0] smp_i,
   // settings
   input  wire arc_pkg::arc_cfg_t  cfg_i,
   // result
   output arc_pkg::arc_res_t       res_o
);
   import arc_pkg::*;

   logic signed [17:0] s_x;
   logic signed [17:0] lvl;
   logic signed [17:0] diff;
   logic signed [34:0] prod;
   logic signed [15:0] val;
   logic               loop;
   arc_res_t           res_d;
   arc_res_t           res_q;

   always_comb begin
      s_x  = {{2{smp_i[15]}}, smp_i};
      loop = 1'b1;
      unique case (cfg_i.fmt)
         ARC_FMT_B10: begin
            lvl  = s_x / ARC_DIV_V;
            loop = 1'b0;
         end
         ARC_FMT_A20: begin
            lvl  = s_x / ARC_DIV_A;
            loop = 1'b0;
         end
         ARC_FMT_T420, ARC_FMT_R420: begin
            lvl = (s_x - ARC_LOOP_MIN) / ARC_DIV_LOOP;
         end
         ARC_FMT_T204, ARC_FMT_R204: begin
            lvl = (ARC_LOOP_MAX - s_x) / ARC_DIV_LOOP;
         end
         default: begin
            lvl  = s_x / ARC_DIV_V;
            loop = 1'b0;
         end
      endcase
      diff = lvl - {{2{cfg_i.offset[15]}}, cfg_i.offset};
      prod = 35'(diff * $signed({1'b0, cfg_i.scale})) / ARC_FULL_W;
      val  = arc_clamp(prod);
      // only the bipolar format carries a sign onward
      if (cfg_i.fmt != ARC_FMT_B10 && val[15]) begin
         val = '0;
      end
      res_d       = res_q;
      res_d.value = val;
      res_d.lost  = loop && (s_x < ARC_LOSS_UA);
      res_d.trip  = (cfg_i.fmt == ARC_FMT_T420) || (cfg_i.fmt == ARC_FMT_T204);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_q <= '0;
      end else if (ce_i && smp_vld_i) begin
         res_q <= res_d;
      end
   end

   assign res_o = res_q;

endmodule // arc_chan

/* verilog/arc_irq.sv */
// sticky interrupt status with read clear and mask
`timescale 1ns/1ps
module arc_irq #(
   parameter int unsigned N = 3
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   // events and software access
   input  wire logic [N-1:0] ev_i,
   input  wire logic         rd_clr_i,
   input  wire logic         mask_we_i,
   input  wire logic [N-1:0] mask_i,
   // state
   output logic      [N-1:0] stat_o,
   output logic      [N-1:0] mask_o,
   output logic              irq_o
);
   logic [N-1:0] stat_d;
   logic [N-1:0] stat_q;
   logic [N-1:0] mask_d;
   logic [N-1:0] mask_q;

   always_comb begin
      // an event in the clearing cycle survives the clear
      stat_d = (rd_clr_i ? '0 : stat_q) | ev_i;
      mask_d = mask_we_i ? mask_i : mask_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= '0;
         mask_q <= '0;
      end else if (ce_i) begin
         stat_q <= stat_d;
         mask_q <= mask_d;
      end
   end

   assign stat_o = stat_q;
   assign mask_o = mask_q;
   assign irq_o  = |(stat_q & mask_q);

endmodule // arc_irq

/* tb/arc_src_model.sv */
// behavioural model of the external analog reference source
`timescale 1ns/1ps
module arc_src_model #(
   parameter int unsigned PERIOD = 5
) (
   // clock
   input  wire logic               clk_i,
   // level asked for by the bench, mV or uA
   input  wire logic signed [15:0] lvl_i,
   // converter sample towards the block
   output logic                    vld_o,
   output logic signed [15:0]      smp_o
);
   int unsigned cnt_q;
   initial begin
      cnt_q = 0;
      vld_o = 1'b0;
      smp_o = 16'h0000;
   end
   // between strobes the data lines toggle, so a design that reads them late sees junk
   always @(posedge clk_i) begin
      if (cnt_q == PERIOD - 1) begin
         cnt_q <= 0;
         vld_o <= 1'b1;
         smp_o <= lvl_i;
      end else begin
         cnt_q <= cnt_q + 1;
         vld_o <= 1'b0;
         smp_o <= ~smp_o;
      end
   end
endmodule // arc_src_model

/* tb/arc_checker.sv */
// port level assertions of the analog reference conditioner
`timescale 1ns/1ps
module arc_checker (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   // wishbone
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // drive side
   input wire logic        fault_rst_i,
   input wire logic [15:0] speed_o,
   input wire logic        ramp_stop_o,
   input wire logic        fault_o,
   input wire logic [7:0]  fault_code_o
);
   import arc_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ****************************************
   // assertions
   // ****************************************
   ack_pulse_a: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   ack_latency_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   unmapped_zero_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && wb_adr_i > ARC_REG_DEM |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   fault_code_a: assert property (fault_o |-> fault_code_o == ARC_INPUT_LOSS_FAULT_CODE)
      else $error("fault without loss code");
   idle_code_a: assert property (!fault_o |-> fault_code_o == 8'h00)
      else $error("fault code without fault");
   fault_hold_a: assert property (fault_o && ce_i && !fault_rst_i
      && !(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ARC_REG_CMD) |=> fault_o)
      else $error("fault dropped without reset");
   fault_stop_a: assert property (fault_o && $past(fault_o) && $past(fault_o, 2)
      |-> speed_o == 16'h0000)
      else $error("speed demand during fault");
   ramp_zero_a: assert property (ramp_stop_o && $past(ramp_stop_o)
      && $past(ramp_stop_o, 2) |-> speed_o == 16'h0000)
      else $error("speed demand during ramp stop");
   one_state_a: assert property (!(fault_o && ramp_stop_o))
      else $error("fault and ramp stop together");
endmodule // arc_checker

bind arc_top arc_checker i_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o, .fault_rst_i, .speed_o, .ramp_stop_o, .fault_o,
   .fault_code_o);

/* tb/testbench.sv */
// self checking testbench of the analog reference conditioner
`timescale 1ns/1ps
module testbench;
   import arc_pkg::*;
   logic               clk_i, rst_i, ce_i, fault_rst_i;
   logic               wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]         wb_adr_i, fault_code_o;
   logic [3:0]         wb_sel_i;
   logic [31:0]        wb_dat_i, wb_dat_o, rd;
   logic               ain1_vld_i, ain2_vld_i, reverse_o, ramp_stop_o, fault_o, irq_o;
   logic signed [15:0] ain1_i, ain2_i, lvl1, lvl2;
   logic [15:0]        speed_o;
   int                 fail_count, tests_run, maxsp;
   arc_top i_dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ain1_vld_i, .ain1_i, .ain2_vld_i,
      .ain2_i, .fault_rst_i, .speed_o, .reverse_o, .ramp_stop_o, .fault_o,
      .fault_code_o, .irq_o);
   // prime periods keep the two sources out of step
   arc_src_model #(.PERIOD(5)) i_src1 (.clk_i, .lvl_i(lvl1), .vld_o(ain1_vld_i),
      .smp_o(ain1_i));
   arc_src_model #(.PERIOD(7)) i_src2 (.clk_i, .lvl_i(lvl2), .vld_o(ain2_vld_i),
      .smp_o(ain2_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) fail_count++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic int exp_pct(arc_fmt_t f, int lvl, int ofs, int scl);
      int p;
      case (f)
         ARC_FMT_U10, ARC_FMT_B10: p = lvl / 10;
         ARC_FMT_A20: p = lvl / 20;
         ARC_FMT_T420, ARC_FMT_R420: p = (lvl - 4000) / 16;
         default: p = (20000 - lvl) / 16;
      endcase
      p = (p - ofs) * scl / 1000;
      p = p > 1000 ? 1000 : p < -1000 ? -1000 : p;
      return (p < 0 && f != ARC_FMT_B10) ? 0 : p;
   endfunction
   task automatic run_case(input int sel, input arc_fmt_t f, input int lvl, input int ofs,
                           input int scl);
      int p;
      int s;
      logic [31:0] c;
      // park both inputs on voltage so a level change cannot trip a loop format
      wb(1'b1, ARC_REG_CTRL, 32'h0000_0000);
      lvl1 <= sel ? 16'sd0 : 16'(lvl);
      lvl2 <= sel ? 16'(lvl) : 16'sd0;
      wb(1'b1, sel ? ARC_REG_OFS2 : ARC_REG_OFS1, ofs);
      wb(1'b1, sel ? ARC_REG_SCL2 : ARC_REG_SCL1, scl);
      wb(1'b1, ARC_REG_MAXSP, maxsp);
      repeat (12) @(posedge clk_i);
      c = 32'(f);
      if (sel != 0) begin
         c = f == ARC_FMT_A20 ? 32'h0000_0110 : f == ARC_FMT_T420 ? 32'h0000_0120
                              : 32'h0000_0100;
      end
      wb(1'b1, ARC_REG_CTRL, c);
      repeat (20) @(posedge clk_i);
      p = exp_pct(f, lvl, ofs, scl);
      s = (p < 0 ? -p : p) * maxsp / 1000;
      wb(1'b0, ARC_REG_DEM, 32'h0000_0000);
      chk("demand", rd, {16'(s), 16'(p)});
      chk("speed", speed_o, s);
      chk("reverse", reverse_o, p < 0);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (60000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      arc_fmt_t f;
      logic     trip;
      {rst_i, ce_i, wb_sel_i} = {1'b1, 1'b1, 4'hf};
      {wb_cyc_i, wb_stb_i, wb_we_i, fault_rst_i} = 4'h0;
      {wb_adr_i, wb_dat_i, lvl1, lvl2} = '0;
      {fail_count, tests_run, maxsp} = {32'd0, 32'd0, 32'd500};
      void'($urandom(32'h83427f37));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("outputs", {speed_o, fault_o, ramp_stop_o, irq_o}, 32'h0000_0000);
      wb(1'b0, ARC_REG_CTRL, 32'h0000_0000);
      chk("ctrl", rd, 32'h0000_0000);
      wb(1'b0, ARC_REG_OFS1, 32'h0000_0000);
      chk("offset", rd, 32'h0000_0000);
      wb(1'b0, ARC_REG_SCL1, 32'h0000_0000);
      chk("scale", rd, 32'h0000_03e8);
      wb(1'b0, 8'h3c, 32'h0000_0000);
      chk("unmapped", rd, 32'h0000_0000);
      $display("test reset done");
      run_case(0, ARC_FMT_U10, 7000, 200, 1000);
      run_case(0, ARC_FMT_U10, 5000, 0, 2000);
      run_case(0, ARC_FMT_U10, 1000, 300, 1000);
      run_case(0, ARC_FMT_B10, -5000, 0, 1000);
      run_case(0, ARC_FMT_B10, 2000, 500, 1000);
      run_case(0, ARC_FMT_T204, 20000, 0, 1000);
      run_case(0, ARC_FMT_R204, 4000, 0, 1000);
      run_case(0, ARC_FMT_A20, 10000, 0, 1000);
      run_case(1, ARC_FMT_U10, 6000, 0, 1000);
      run_case(1, ARC_FMT_A20, 10000, 0, 1000);
      run_case(1, ARC_FMT_T420, 20000, 0, 500);
      $display("test corners done");
      for (int i = 0; i < 24; i++) begin
         f = arc_fmt_t'($urandom_range(6));
         maxsp = $urandom_range(1000);
         run_case(0, f, f < ARC_FMT_A20 ? int'($urandom_range(20000)) - 10000
                  : f == ARC_FMT_A20 ? int'($urandom_range(20000))
                  : 3000 + int'($urandom_range(17000)),
                  int'($urandom_range(400)) - 200, $urandom_range(2000));
      end
      $display("test random done");
      wb(1'b1, ARC_REG_OFS1, 32'h0000_0000);
      wb(1'b1, ARC_REG_SCL1, 32'h0000_03e8);
      wb(1'b1, ARC_REG_MAXSP, 32'h0000_01f4);
      for (int i = 0; i < 4; i++) begin
         f = arc_fmt_t'(3 + i);
         trip = (i % 2 == 0);
         lvl1 <= 16'sd12000;
         wb(1'b1, ARC_REG_CTRL, 32'(f));
         wb(1'b1, ARC_REG_IMASK, i != 0 ? 32'h0000_0007 : 32'h0000_0000);
         wb(1'b0, ARC_REG_ISTAT, 32'h0000_0000);
         lvl1 <= 16'sd2000;
         repeat (20) @(posedge clk_i);
         chk("fault", fault_o, trip);
         chk("ramp", ramp_stop_o, !trip);
         chk("code", fault_code_o, trip ? ARC_INPUT_LOSS_FAULT_CODE : 8'h00);
         chk("stopped", speed_o, 32'h0000_0000);
         wb(1'b0, ARC_REG_STAT, 32'h0000_0000);
         chk("status", rd, trip ? 32'h0000_070c : 32'h0000_000a);
         chk("irq masked", irq_o, i != 0);
         wb(1'b1, ARC_REG_IMASK, 32'h0000_0007);
         chk("irq", irq_o, 1'b1);
         wb(1'b0, ARC_REG_ISTAT, 32'h0000_0000);
         chk("istat", rd & 32'h0000_0003, trip ? 32'h0000_0001 : 32'h0000_0002);
         chk("irq cleared", irq_o, 1'b0);
         lvl1 <= 16'sd12000;
         repeat (20) @(posedge clk_i);
         chk("latched", fault_o, trip);
         chk("ramp off", ramp_stop_o, 1'b0);
         wb(1'b0, ARC_REG_ISTAT, 32'h0000_0000);
         chk("recovered", rd & 32'h0000_0004, 32'h0000_0004);
         if (i == 0) begin
            fault_rst_i <= 1'b1;
            @(posedge clk_i);
            fault_rst_i <= 1'b0;
         end else if (trip) begin
            wb(1'b1, ARC_REG_CMD, 32'h0000_0001);
         end
         repeat (20) @(posedge clk_i);
         chk("resumed", {fault_o, speed_o}, 32'h0000_00fa);
      end
      // a low enable must freeze the loss handling as well as the demand
      ce_i <= 1'b0;
      lvl1 <= 16'sd2000;
      repeat (20) @(posedge clk_i);
      chk("frozen", {ramp_stop_o, speed_o}, 32'h0000_00fa);
      ce_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk("thawed", ramp_stop_o, 1'b1);
      $display("test loss done");
      tally_and_finish();
   end
endmodule // testbench
